// File: lpc_clock_ctrl.v
`default_nettype none
`include "lpc_regs.vh"
module lpc_clock_ctrl (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Command byte from serial interface
	input wire [7:0] cmdByte,
	input wire cmdValid,
	// Mode settings
	input wire power_down_bit,
	input wire displayEnable,
	input wire pwmEnable,
	// Per-output mode and static levels
	input wire [11:0] auxMode,
	input wire [5:0] aux_static_levels,
	input wire [5:0] pwmLevels,
	input wire [5:0] lcdSegIn,
	input wire [7:0] lcdBpIn,
	// Shared clock pin
	input wire shared_clock_pin_in,
	output reg shared_clock_pin_out,
	output reg shared_clock_pin_oe_n,
	// Clock status and ticks
	output reg oscRunning,
	output reg lcdClkTick,
	output reg pwmClkTick,
	output reg ext_freq_select,
	output reg clock_out_enable,
	output reg clockSource,
	// Drive outputs
	output reg [7:0] lcdBpOut,
	output reg [5:0] aux_static_output
);
	reg pinSync1_reg;
	reg pinSync2_reg;
	reg pinLast_reg;
	reg oscRun;
	wire shared_clock_pin;
	wire oscTick;
	wire outClk;
	wire extEdge;
	integer i;

	// Two-flop synchroniser for the pin clock
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pinSync1_reg <= 1'b0;
			pinSync2_reg <= 1'b0;
			pinLast_reg <= 1'b0;
		end else begin
			pinSync1_reg <= shared_clock_pin_in;
			pinSync2_reg <= pinSync1_reg;
			pinLast_reg <= pinSync2_reg;
		end
	end
	assign extEdge = pinSync2_reg & ~pinLast_reg;

	// Oscillator-control command capture
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_freq_select <= `LPC_EFR_RST;
			clock_out_enable <= `LPC_COE_RST;
			clockSource <= `LPC_OSC_RST;
		end else if (cmdValid && cmdByte[`LPC_OSC_CMD_MSB:`LPC_OSC_CMD_LSB]
				== `LPC_OSC_CMD_CODE) begin
			ext_freq_select <= cmdByte[`LPC_EFR_BIT];
			clock_out_enable <= cmdByte[`LPC_COE_BIT];
			clockSource <= cmdByte[`LPC_OSC_BIT];
		end
	end

	// Internal oscillator enable
	always @* begin
		if (power_down_bit)
			oscRun = 1'b0;
		else if (!clockSource)
			oscRun = 1'b1;
		else
			oscRun = pwmEnable & ~ext_freq_select;
	end

	// Nominal 230 kHz oscillator
	lpc_div #(.HALF(`LPC_OSC_HALF)) uOsc (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(oscRun),
		.tickIn(1'b1),
		.clkOut(shared_clock_pin),
		.tickOut(oscTick)
	);

	// Prescaled oscillator for the clock pin
	lpc_div #(.HALF(`LPC_OUT_DIV / 2)) uPre (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(oscRun),
		.tickIn(oscTick),
		.clkOut(outClk),
		.tickOut()
	);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shared_clock_pin_out <= 1'b0;
			shared_clock_pin_oe_n <= 1'b1;
			oscRunning <= 1'b0;
			lcdClkTick <= 1'b0;
			pwmClkTick <= 1'b0;
			lcdBpOut <= 8'h00;
			aux_static_output <= 6'h00;
		end else begin
			oscRunning <= oscRun;
			// Clock pin
			if (clockSource || !clock_out_enable) begin
				shared_clock_pin_oe_n <= 1'b1;
				shared_clock_pin_out <= 1'b0;
			end else if (power_down_bit) begin
				shared_clock_pin_oe_n <= 1'b0;
				shared_clock_pin_out <= 1'b1;
			end else begin
				shared_clock_pin_oe_n <= 1'b0;
				shared_clock_pin_out <= outClk;
			end
			// Timing ticks; frequency select ignored on internal
			if (!clockSource) begin
				lcdClkTick <= oscTick;
				pwmClkTick <= oscTick;
			end else begin
				lcdClkTick <= extEdge;
				pwmClkTick <= ext_freq_select ? extEdge : oscTick;
			end
			// LCD backplanes grounded at once
			if (power_down_bit || !displayEnable)
				lcdBpOut <= 8'h00;
			else
				lcdBpOut <= lcdBpIn;
			// Combined segment/aux outputs
			for (i = 0; i < 6; i = i + 1) begin
				case (auxMode[2*i +: 2])
					`LPC_MODE_STATIC:
						aux_static_output[i] <= aux_static_levels[i];
					`LPC_MODE_PWM:
						aux_static_output[i] <= power_down_bit ?
							aux_static_levels[i] : pwmLevels[i];
					default:
						aux_static_output[i] <=
							(power_down_bit || !displayEnable) ?
							1'b0 : lcdSegIn[i];
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: lpc_regs.vh
`ifndef LPC_REGS_VH
`define LPC_REGS_VH
// Oscillator-control command byte
`define LPC_OSC_CMD_MSB 7
`define LPC_OSC_CMD_LSB 3
`define LPC_OSC_CMD_CODE 5'h03
`define LPC_EFR_BIT 2
`define LPC_COE_BIT 1
`define LPC_OSC_BIT 0
// Reset values
`define LPC_EFR_RST 1'h0
`define LPC_COE_RST 1'h0
`define LPC_OSC_RST 1'h0
// Output modes
`define LPC_MODE_LCD0 2'h0
`define LPC_MODE_LCD1 2'h1
`define LPC_MODE_STATIC 2'h2
`define LPC_MODE_PWM 2'h3
// Nominal internal oscillator 230 kHz from 40 MHz: half period count
`define LPC_CLK_HZ 40000000
`define LPC_OSC_HZ 230000
`define LPC_OSC_HALF ((`LPC_CLK_HZ / `LPC_OSC_HZ) / 2)
// Prescale of oscillator for clock output, 230 kHz / 24 = 9.6 kHz
`define LPC_OUT_DIV 24
`endif

// File: lpc_div.v
`default_nettype none
`include "lpc_regs.vh"
module lpc_div #(
	parameter integer HALF = 4
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Control
	input wire run,
	input wire tickIn,
	// Result
	output reg clkOut,
	output reg tickOut
);
	reg [15:0] cnt_reg;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
			clkOut <= 1'b0;
			tickOut <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 16'h0000;
			clkOut <= 1'b0;
			tickOut <= 1'b0;
		end else begin
			tickOut <= 1'b0;
			if (tickIn) begin
				if (cnt_reg == HALF[15:0] - 16'h0001) begin
					cnt_reg <= 16'h0000;
					clkOut <= ~clkOut;
					tickOut <= ~clkOut;
				end else begin
					cnt_reg <= cnt_reg + 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: lpc_clock_ctrl_props.sv
`default_nettype none
module lpc_clock_ctrl_props(input wire logic clk_sys, rst_n, cmdValid,
	power_down_bit, displayEnable, ext_freq_select, clock_out_enable,
	clockSource, shared_clock_pin_out, shared_clock_pin_oe_n, oscRunning,
	input wire logic [7:0] cmdByte, lcdBpOut);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
wire logic hit = cmdValid && cmdByte[7:3] == 5'h03;
wire logic [2:0] cfg = {ext_freq_select, clock_out_enable, clockSource};
wire logic intl = !clockSource;
property p_take; hit |=> cfg == $past(cmdByte[2:0]); endproperty
a_take: assert property (p_take) else $error("take");
property p_hold; !hit |=> $stable(cfg); endproperty
a_hold: assert property (p_hold) else $error("hold");
property p_dark; !displayEnable |=> lcdBpOut == 8'h00; endproperty
a_dark: assert property (p_dark) else $error("dark");
property p_osc; power_down_bit [*2] |-> !oscRunning; endproperty
a_osc: assert property (p_osc) else $error("osc");
property p_tri;
	intl && !clock_out_enable |=> shared_clock_pin_oe_n;
endproperty
a_tri: assert property (p_tri) else $error("tri");
property p_in; clockSource |=> shared_clock_pin_oe_n; endproperty
a_in: assert property (p_in) else $error("in");
property p_drv;
	intl && clock_out_enable |=> !shared_clock_pin_oe_n;
endproperty
a_drv: assert property (p_drv) else $error("drv");
property p_high;
	intl && clock_out_enable && power_down_bit |=> shared_clock_pin_out;
endproperty
a_high: assert property (p_high) else $error("high");
endmodule
bind lpc_clock_ctrl lpc_clock_ctrl_props i_props(.clk_sys(clk_sys),
	.rst_n(rst_n), .cmdValid(cmdValid), .power_down_bit(power_down_bit),
	.displayEnable(displayEnable), .ext_freq_select(ext_freq_select),
	.clock_out_enable(clock_out_enable), .clockSource(clockSource),
	.shared_clock_pin_out(shared_clock_pin_out),
	.shared_clock_pin_oe_n(shared_clock_pin_oe_n),
	.oscRunning(oscRunning), .cmdByte(cmdByte), .lcdBpOut(lcdBpOut));
`default_nettype wire

// File: lpc_host.sv
`default_nettype none
module lpc_host(input wire logic clk_sys, extRun,
	output logic [7:0] cmdByte, output logic cmdValid, extPin);
timeunit 1ns;
timeprecision 100ps;
logic [5:0] cnt = 6'h00;
initial cmdByte = 8'h00;
initial cmdValid = 0;
always @(posedge clk_sys) cnt <= cnt + 6'h01;
// Clock only when asked, else a busy pattern
assign extPin = extRun ? cnt[5] : cnt[0];
task send(input logic [7:0] b);
	@(posedge clk_sys) #2;
	cmdByte = b;
	cmdValid = 1;
	@(posedge clk_sys) #2;
	cmdValid = 0;
	cmdByte = ~b;
endtask
endmodule
`default_nettype wire

// File: lpc_clock_ctrl_bench.sv
`default_nettype none
module lpc_clock_ctrl_bench;
timeunit 1ns;
timeprecision 100ps;
logic clk_sys = 0, rst_n = 0, pd = 0, de = 0, pe = 0, run = 0;
logic [11:0] md = 12'hAAA;
logic [5:0] sl = 6'h2D, pl = 6'h12, si = 6'h00;
logic [7:0] bi = 8'hA5;
wire logic lt, pt;
wire logic [7:0] cb, bo;
wire logic cv, po, oe, ep, osc, ef, ce, cs;
wire logic [5:0] ax;
int n_mismatch = 0, checks = 0;
always #12.5 clk_sys = ~clk_sys;
lpc_host i_host(.clk_sys(clk_sys), .extRun(run), .cmdByte(cb),
	.cmdValid(cv), .extPin(ep));
lpc_clock_ctrl i_dut(.clk_sys(clk_sys), .rst_n(rst_n), .cmdByte(cb),
	.cmdValid(cv), .power_down_bit(pd), .displayEnable(de),
	.pwmEnable(pe), .auxMode(md), .aux_static_levels(sl),
	.pwmLevels(pl), .lcdSegIn(si), .lcdBpIn(bi),
	.shared_clock_pin_in(oe ? ep : po), .shared_clock_pin_out(po),
	.shared_clock_pin_oe_n(oe), .oscRunning(osc), .lcdClkTick(lt),
	.pwmClkTick(pt), .ext_freq_select(ef), .clock_out_enable(ce),
	.clockSource(cs), .lcdBpOut(bo), .aux_static_output(ax));
task chk(input string s, input logic [7:0] e, g);
	checks++;
	if (g !== e) begin
		n_mismatch++;
		$display("CHECK FAILED %s exp %h got %h", s, e, g);
	end
endtask
task results;
	if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask
task tk(input int n);
	repeat (n) @(posedge clk_sys);
	#2;
endtask
// Count timing ticks over a window
task cnt_ticks(input int n, output int a, output int b);
	a = 0;
	b = 0;
	repeat (n) begin
		tk(1);
		a += (lt === 1'b1);
		b += (pt === 1'b1);
	end
endtask
task t_cmd;
	for (int i = 0; i < 8; i++) begin
		i_host.send(8'h18 | 8'(i));
		tk(1);
		chk("cfg", 8'(i), {ef, ce, cs});
	end
	i_host.send(8'h3A);
	tk(1);
	chk("cfg", 8'h07, {ef, ce, cs});
endtask
task t_pd;
	int n;
	logic v;
	de = 1;
	tk(2);
	chk("bp", 8'hA5, bo);
	de = 0;
	tk(1);
	chk("bp", 8'h00, bo);
	chk("aux", 8'h2D, ax);
	i_host.send(8'h1A);
	md = 12'hFFF;
	de = 1;
	pd = 1;
	tk(3);
	chk("pin", 8'h01, {oe, po});
	chk("osc", 8'h00, osc);
	chk("bp", 8'h00, bo);
	chk("aux", 8'h2D, ax);
	pd = 0;
	n = 0;
	repeat (9000) begin
		v = po;
		tk(1);
		n += (po !== v);
	end
	chk("tgl", 8'h01, 8'(n > 1));
endtask
task t_ext;
	int a, b;
	de = 0;
	pe = 1;
	run = 1;
	i_host.send(8'h1D);
	tk(3);
	chk("oe", 8'h01, oe);
	chk("osc", 8'h00, osc);
	cnt_ticks(640, a, b);
	chk("lcdtick", 8'd10, 8'(a));
	chk("pwmtick", 8'd10, 8'(b));
	i_host.send(8'h19);
	tk(3);
	chk("osc", 8'h01, osc);
	cnt_ticks(640, a, b);
	chk("lcdtick", 8'd10, 8'(a));
	chk("pwmtick", 8'h01, 8'(b >= 3 && b <= 4));
endtask
initial begin
	tk(10);
	rst_n = 1;
	tk(1);
	chk("rst", 8'h01, {ef, ce, cs, oe});
	t_cmd;
	t_pd;
	t_ext;
	results;
end
endmodule
`default_nettype wire
